// ### design/spr_sequencer.sv
// Host-side power, reset, clock and streaming sequencer for the image sensor
//
// Contract
// - PLL supply on first.
// - Input clock off until last rail settles.
// - Reset low at least 1 ms after rails settle.
// - No configuration before 150000 input clocks after reset release.
// - Settings written only in software standby.
// - At least 1 ms PLL lock wait before streaming.
// - Streaming starts by writing one to bit 2 of sensor_control.
// - Stop streaming, reach soft standby, then remove supplies.
// - Rails go off: serial output, core, IO, analog and pixel, PLL.
// - All supplies stay off at least 100 ms before next power-up.
//
// The AXI4-Lite register port was decided locally.
`timescale 1ns/1ps
`include "spr_consts.svh"
module spr_sequencer #(
  parameter int MS_CYC     = (`SPR_HARD_RESET_MS * 1000000 + `SPR_CLK_PERIOD_NS - 1) / `SPR_CLK_PERIOD_NS,
  parameter int PLL_CYC    = (`SPR_PLL_LOCK_MS * 1000000 + `SPR_CLK_PERIOD_NS - 1) / `SPR_CLK_PERIOD_NS,
  parameter int INIT_CLKS  = `SPR_INIT_EXTCLKS,
  parameter int OFF_CYC    = (`SPR_OFF_TIME_MS * 1000000 + `SPR_CLK_PERIOD_NS - 1) / `SPR_CLK_PERIOD_NS,
  parameter int EXT_HALF   = `SPR_EXTERNAL_INPUT_CLOCK_HALF
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             pll_supply_en,
  output logic             analog_supply_en,
  output logic             pixel_array_supply_en,
  output logic             io_supply_en,
  output logic             core_supply_en,
  output logic             serial_output_supply_en,
  output logic             external_input_clock,
  output logic             sensor_reset_n,
  output logic             ser_req,
  output logic [15:0]      ser_addr,
  output logic [15:0]      ser_data,
  input  wire logic        ser_ack
);
  localparam int RAIL_CYC = (`SPR_RAIL_STEP_US * 1000 + `SPR_CLK_PERIOD_NS - 1) / `SPR_CLK_PERIOD_NS;

  if (MS_CYC < 1 || PLL_CYC < 1 || INIT_CLKS < 1 || OFF_CYC < 1) begin : g_chk
    $error("Timing parameters must be at least one");
  end

  spr_pkg::spr_state_e st_q;
  logic [`SPR_NUM_RAILS-1:0] rail_q;
  logic [2:0]  idx_q;
  logic [31:0] tmr_q;
  logic        clk_run_q;
  logic        rst_n_q;
  logic [15:0] stream_val_q;
  logic [15:0] standby_q;
  logic        ext_rise;
  logic        wr_en;
  logic [7:0]  wr_addr;
  logic [31:0] wr_data;
  logic [3:0]  wr_strb;
  logic        wr_ok;
  logic [31:0] rd_data;
  logic        rd_ok;
  logic        up_cmd;
  logic        down_cmd;
  logic        cfg_done_cmd;
  logic        launch_cmd;
  logic        launch_on;
  logic        launch_off;
  logic        tick;
  logic        tmr_done;
  logic        go_down;

  // Byte-lane merge for the stream value and standby own registers
  function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0]  strb);
    merge16 = old_v;
    if (strb[0]) merge16[7:0] = new_v[7:0];
    if (strb[1]) merge16[15:8] = new_v[15:8];
  endfunction : merge16

  function automatic logic known_addr(input logic [7:0] a);
    known_addr = (a == `SPR_ADDR_CTRL) || (a == `SPR_ADDR_STATUS) || (a == `SPR_ADDR_SERCMD)
              || (a == `SPR_ADDR_STREAMVAL) || (a == `SPR_ADDR_STANDBY);
  endfunction : known_addr

  // ********
  // Bus slave and input clock divider
  // ********
  spr_axil_slave u_bus (
    .aclk    (aclk),
    .aresetn (aresetn),
    .awaddr  (s_axi_awaddr),
    .awvalid (s_axi_awvalid),
    .awready (s_axi_awready),
    .wdata   (s_axi_wdata),
    .wstrb   (s_axi_wstrb),
    .wvalid  (s_axi_wvalid),
    .wready  (s_axi_wready),
    .bresp   (s_axi_bresp),
    .bvalid  (s_axi_bvalid),
    .bready  (s_axi_bready),
    .araddr  (s_axi_araddr),
    .arvalid (s_axi_arvalid),
    .arready (s_axi_arready),
    .rdata   (s_axi_rdata),
    .rresp   (s_axi_rresp),
    .rvalid  (s_axi_rvalid),
    .rready  (s_axi_rready),
    .wr_en   (wr_en),
    .wr_addr (wr_addr),
    .wr_data (wr_data),
    .wr_strb (wr_strb),
    .wr_ok   (wr_ok),
    .rd_data (rd_data),
    .rd_ok   (rd_ok)
  );

  spr_clk_div #(
    .HALF (EXT_HALF)
  ) u_div (
    .aclk    (aclk),
    .aresetn (aresetn),
    .run     (clk_run_q),
    .clk_q   (external_input_clock),
    .rise_q  (ext_rise)
  );

  // ********
  // Register decode
  // ********
  always_comb begin
    wr_ok = known_addr(wr_addr);
    rd_ok = known_addr(s_axi_araddr);
    if (s_axi_araddr == `SPR_ADDR_STATUS) begin
      rd_data = {20'h00000, rst_n_q, clk_run_q, rail_q, ser_req, st_q};
    end else if (s_axi_araddr == `SPR_ADDR_SERCMD) begin
      rd_data = {ser_addr, ser_data};
    end else if (s_axi_araddr == `SPR_ADDR_STREAMVAL) begin
      rd_data = {16'h0000, stream_val_q};
    end else if (s_axi_araddr == `SPR_ADDR_STANDBY) begin
      rd_data = {16'h0000, standby_q};
    end else begin
      rd_data = 32'h0000_0000;
    end
  end

  always_comb begin
    up_cmd       = wr_en && wr_addr == `SPR_ADDR_CTRL && wr_strb[0] && wr_data[`SPR_CTRL_UP];
    down_cmd     = wr_en && wr_addr == `SPR_ADDR_CTRL && wr_strb[0] && wr_data[`SPR_CTRL_DOWN];
    cfg_done_cmd = wr_en && wr_addr == `SPR_ADDR_CTRL && wr_strb[0] && wr_data[`SPR_CTRL_CFG_DONE];
    // Settings only flow while the sensor sits in software standby
    launch_cmd   = wr_en && wr_addr == `SPR_ADDR_SERCMD && (&wr_strb)
                && st_q == spr_pkg::ST_CONFIG && !ser_req;
    launch_on    = st_q == spr_pkg::ST_PLL_WAIT && tmr_done;
    launch_off   = st_q == spr_pkg::ST_STREAMING && down_cmd;
    tick         = (st_q == spr_pkg::ST_INIT_WAIT) ? ext_rise : 1'b1;
    tmr_done     = tmr_q == 32'h0000_0000;
    go_down      = down_cmd && (st_q == spr_pkg::ST_RAMP_UP || st_q == spr_pkg::ST_RESET_HOLD
                || st_q == spr_pkg::ST_INIT_WAIT || (st_q == spr_pkg::ST_CONFIG && !ser_req));
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stream_val_q <= `SPR_STREAMVAL_RST;
      standby_q    <= `SPR_STANDBY_RST;
    end else if (wr_en && wr_addr == `SPR_ADDR_STREAMVAL) begin
      stream_val_q <= merge16(stream_val_q, wr_data, wr_strb);
    end else if (wr_en && wr_addr == `SPR_ADDR_STANDBY) begin
      standby_q <= merge16(standby_q, wr_data, wr_strb);
    end
  end

  // ********
  // Serial write request towards the two-wire master
  // ********
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ser_req  <= 1'b0;
      ser_addr <= 16'h0000;
      ser_data <= 16'h0000;
    end else if (launch_cmd) begin
      ser_req  <= 1'b1;
      ser_addr <= wr_data[31:16];
      ser_data <= wr_data[15:0];
    end else if (launch_on) begin
      ser_req  <= 1'b1;
      ser_addr <= `SPR_SENSOR_CONTROL;
      ser_data <= stream_val_q | (16'h0001 << `SPR_STREAM_BIT);
    end else if (launch_off) begin
      ser_req  <= 1'b1;
      ser_addr <= `SPR_SENSOR_CONTROL;
      ser_data <= stream_val_q & ~(16'h0001 << `SPR_STREAM_BIT);
    end else if (ser_ack) begin
      ser_req <= 1'b0;
    end
  end

  // ********
  // Sequencing state machine
  // ********
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q      <= spr_pkg::ST_OFF;
      rail_q    <= '0;
      idx_q     <= 3'h0;
      tmr_q     <= 32'h0000_0000;
      clk_run_q <= 1'b0;
      rst_n_q   <= 1'b0;
    end else begin
      if (!tmr_done && tick) begin
        tmr_q <= tmr_q - 32'h0000_0001;
      end
      case (st_q)
        spr_pkg::ST_OFF: begin
          if (up_cmd) begin
            rail_q[`SPR_RAIL_PLL] <= 1'b1;
            idx_q <= 3'(`SPR_RAIL_ANALOG);
            tmr_q <= 32'(RAIL_CYC);
            st_q  <= spr_pkg::ST_RAMP_UP;
          end
        end
        spr_pkg::ST_RAMP_UP: begin
          if (tmr_done && idx_q == 3'(`SPR_NUM_RAILS)) begin
            // Last rail has had its settle step
            clk_run_q <= 1'b1;
            tmr_q     <= 32'(MS_CYC);
            st_q      <= spr_pkg::ST_RESET_HOLD;
          end else if (tmr_done) begin
            rail_q[idx_q] <= 1'b1;
            idx_q         <= idx_q + 3'h1;
            tmr_q         <= 32'(RAIL_CYC);
          end
        end
        spr_pkg::ST_RESET_HOLD: begin
          if (tmr_done) begin
            rst_n_q <= 1'b1;
            tmr_q   <= 32'(INIT_CLKS);
            st_q    <= spr_pkg::ST_INIT_WAIT;
          end
        end
        spr_pkg::ST_INIT_WAIT: begin
          if (tmr_done) begin
            st_q <= spr_pkg::ST_CONFIG;
          end
        end
        spr_pkg::ST_CONFIG: begin
          if (cfg_done_cmd && !ser_req) begin
            tmr_q <= 32'(PLL_CYC);
            st_q  <= spr_pkg::ST_PLL_WAIT;
          end
        end
        spr_pkg::ST_PLL_WAIT: begin
          if (tmr_done) begin
            st_q <= spr_pkg::ST_STREAM_ON;
          end
        end
        spr_pkg::ST_STREAM_ON: begin
          if (ser_ack) begin
            st_q <= spr_pkg::ST_STREAMING;
          end
        end
        spr_pkg::ST_STREAMING: begin
          if (down_cmd) begin
            st_q <= spr_pkg::ST_STREAM_OFF;
          end
        end
        spr_pkg::ST_STREAM_OFF: begin
          if (ser_ack) begin
            // Time for the sensor to close its row or frame
            tmr_q <= 32'(standby_q) * 32'(MS_CYC);
            st_q  <= spr_pkg::ST_STANDBY_WAIT;
          end
        end
        spr_pkg::ST_STANDBY_WAIT: begin
          if (tmr_done) begin
            clk_run_q <= 1'b0;
            rst_n_q   <= 1'b0;
            idx_q     <= 3'(`SPR_RAIL_SERIAL);
            tmr_q     <= 32'(RAIL_CYC);
            st_q      <= spr_pkg::ST_RAMP_DOWN;
          end
        end
        spr_pkg::ST_RAMP_DOWN: begin
          // Reverse of power-up: serial output first, PLL last
          if (tmr_done) begin
            rail_q[idx_q] <= 1'b0;
            tmr_q         <= 32'(RAIL_CYC);
            if (idx_q == 3'(`SPR_RAIL_PLL)) begin
              tmr_q <= 32'(OFF_CYC);
              st_q  <= spr_pkg::ST_DISCHARGE;
            end else begin
              idx_q <= idx_q - 3'h1;
            end
          end
        end
        spr_pkg::ST_DISCHARGE: begin
          if (tmr_done) begin
            st_q <= spr_pkg::ST_OFF;
          end
        end
        default: begin
          st_q <= spr_pkg::ST_OFF;
        end
      endcase
      // Not streaming yet, so no standby wait is needed on the way down
      if (go_down) begin
        clk_run_q <= 1'b0;
        rst_n_q   <= 1'b0;
        idx_q     <= 3'(`SPR_RAIL_SERIAL);
        tmr_q     <= 32'(RAIL_CYC);
        st_q      <= spr_pkg::ST_RAMP_DOWN;
      end
    end
  end

  // ********
  // Pin outputs, each straight from a flop
  // ********
  assign pll_supply_en           = rail_q[`SPR_RAIL_PLL];
  assign analog_supply_en        = rail_q[`SPR_RAIL_ANALOG];
  assign pixel_array_supply_en   = rail_q[`SPR_RAIL_ANALOG];
  assign io_supply_en            = rail_q[`SPR_RAIL_IO];
  assign core_supply_en          = rail_q[`SPR_RAIL_CORE];
  assign serial_output_supply_en = rail_q[`SPR_RAIL_SERIAL];
  assign sensor_reset_n          = rst_n_q;
endmodule : spr_sequencer

// ### include/spr_consts.svh
// Constants for the sensor power and reset sequencer
`ifndef SPR_CONSTS_SVH
`define SPR_CONSTS_SVH
// ********
// Own register byte offsets
// ********
`define SPR_ADDR_CTRL       8'h00
`define SPR_ADDR_STATUS     8'h04
`define SPR_ADDR_SERCMD     8'h08
`define SPR_ADDR_STREAMVAL  8'h0c
`define SPR_ADDR_STANDBY    8'h10
`define SPR_CTRL_UP         0
`define SPR_CTRL_DOWN       1
`define SPR_CTRL_CFG_DONE   2
`define SPR_STREAMVAL_RST   16'h0000
`define SPR_STANDBY_RST     16'h0064
`define SPR_RESP_OKAY       2'h0
`define SPR_RESP_SLVERR     2'h2
// ********
// Sensor side
// ********
`define SPR_SENSOR_CONTROL  16'h301a
`define SPR_STREAM_BIT      2
`define SPR_NUM_RAILS       5
`define SPR_RAIL_PLL        0
`define SPR_RAIL_ANALOG     1
`define SPR_RAIL_IO         2
`define SPR_RAIL_CORE       3
`define SPR_RAIL_SERIAL     4
// ********
// Timing, in printed units
// ********
`define SPR_CLK_PERIOD_NS   40
`define SPR_RAIL_STEP_US    10
`define SPR_HARD_RESET_MS   1
`define SPR_INIT_EXTCLKS    150000
`define SPR_PLL_LOCK_MS     1
`define SPR_OFF_TIME_MS     100
`define SPR_EXTERNAL_INPUT_CLOCK_HALF     1
`endif

// ### include/spr_pkg.sv
// Types shared by the sequencer files
package spr_pkg;
  typedef enum logic [3:0] {
    ST_OFF, ST_RAMP_UP, ST_RESET_HOLD, ST_INIT_WAIT, ST_CONFIG, ST_PLL_WAIT,
    ST_STREAM_ON, ST_STREAMING, ST_STREAM_OFF, ST_STANDBY_WAIT, ST_RAMP_DOWN,
    ST_DISCHARGE
  } spr_state_e;
endpackage : spr_pkg

// ### design/spr_clk_div.sv
// Divider that makes the sensor input clock from aclk
`timescale 1ns/1ps
module spr_clk_div #(
  parameter int HALF = 1
) (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic run,
  output logic      clk_q,
  output logic      rise_q
);
  logic [15:0] cnt_q;

  if (HALF < 1 || HALF > 65535) begin : g_chk
    $error("HALF out of range");
  end

  // Drops low at once when run falls, even partway through a high phase
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q  <= 16'h0000;
      clk_q  <= 1'b0;
      rise_q <= 1'b0;
    end else begin
      rise_q <= 1'b0;
      if (!run) begin
        cnt_q <= 16'h0000;
        clk_q <= 1'b0;
      end else if (cnt_q == 16'(HALF - 1)) begin
        cnt_q  <= 16'h0000;
        clk_q  <= ~clk_q;
        rise_q <= ~clk_q;
      end else begin
        cnt_q <= cnt_q + 16'h0001;
      end
    end
  end
endmodule : spr_clk_div

// ### design/spr_axil_slave.sv
// AXI4-Lite slave front end for the sequencer registers
`timescale 1ns/1ps
module spr_axil_slave (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  output logic             wr_en,
  output logic [7:0]       wr_addr,
  output logic [31:0]      wr_data,
  output logic [3:0]       wr_strb,
  input  wire logic        wr_ok,
  input  wire logic [31:0] rd_data,
  input  wire logic        rd_ok
);
  logic aw_have_q;
  logic w_have_q;

  // ****************************************
  // Write channel
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready   <= 1'b1;
      wready    <= 1'b1;
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      wr_addr   <= 8'h00;
      wr_data   <= 32'h0000_0000;
      wr_strb   <= 4'h0;
      wr_en     <= 1'b0;
      bvalid    <= 1'b0;
      bresp     <= `SPR_RESP_OKAY;
    end else begin
      wr_en <= 1'b0;
      if (awvalid && awready) begin
        wr_addr   <= awaddr;
        awready   <= 1'b0;
        aw_have_q <= 1'b1;
      end
      if (wvalid && wready) begin
        wr_data  <= wdata;
        wr_strb  <= wstrb;
        wready   <= 1'b0;
        w_have_q <= 1'b1;
      end
      if (aw_have_q && w_have_q) begin
        wr_en     <= 1'b1;
        aw_have_q <= 1'b0;
        w_have_q  <= 1'b0;
        bvalid    <= 1'b1;
        bresp     <= wr_ok ? `SPR_RESP_OKAY : `SPR_RESP_SLVERR;
      end
      if (bvalid && bready) begin
        bvalid  <= 1'b0;
        awready <= 1'b1;
        wready  <= 1'b1;
      end
    end
  end

  // ****************************************
  // Read channel
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= `SPR_RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rdata   <= rd_data;
      rresp   <= rd_ok ? `SPR_RESP_OKAY : `SPR_RESP_SLVERR;
    end else if (rvalid && rready) begin
      rvalid  <= 1'b0;
      arready <= 1'b1;
    end
  end
endmodule : spr_axil_slave

// ### verif/spr_checker.sv
// Port assertions for the sensor power and reset sequencer
`timescale 1ns/1ps
`include "spr_consts.svh"
module spr_checker #(
  parameter int MS_CYC    = 20,
  parameter int PLL_CYC   = 20,
  parameter int INIT_CLKS = 10,
  parameter int OFF_CYC   = 30
) (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        pll_supply_en,
  input wire logic        analog_supply_en,
  input wire logic        pixel_array_supply_en,
  input wire logic        io_supply_en,
  input wire logic        core_supply_en,
  input wire logic        serial_output_supply_en,
  input wire logic        external_input_clock,
  input wire logic        sensor_reset_n,
  input wire logic        ser_req,
  input wire logic [15:0] ser_addr,
  input wire logic [15:0] ser_data,
  input wire logic        ser_ack
);
  logic [15:0] hold_q, init_q, lock_q, off_q;
  logic        seen_q, clkp_q, strm_q, son;
  assign son = ser_req && ser_addr == `SPR_SENSOR_CONTROL && ser_data[`SPR_STREAM_BIT];
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Counters other than hold_q saturate so a long idle spell never wraps into a false pass
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {hold_q, init_q, lock_q, seen_q, clkp_q, strm_q} <= '0;
      off_q <= 16'hffff;
    end else begin
      clkp_q <= external_input_clock;
      seen_q <= serial_output_supply_en && (seen_q || external_input_clock);
      hold_q <= (seen_q && !sensor_reset_n) ? hold_q + 16'h1 : 16'h0;
      if (!sensor_reset_n) init_q <= '0;
      else if (external_input_clock && !clkp_q && init_q != 16'hffff) init_q <= init_q + 16'h1;
      if (ser_ack || !sensor_reset_n) lock_q <= '0;
      else if (lock_q != 16'hffff) lock_q <= lock_q + 16'h1;
      if (pll_supply_en) off_q <= '0;
      else if (off_q != 16'hffff) off_q <= off_q + 16'h1;
      if (ser_req && ser_ack && ser_addr == `SPR_SENSOR_CONTROL) strm_q <= ser_data[`SPR_STREAM_BIT];
    end
  end
  a_pll_first: assert property (analog_supply_en || io_supply_en || core_supply_en |-> pll_supply_en)
    else $error("pll late");
  a_rail_chain: assert property ((!serial_output_supply_en || core_supply_en) && (!core_supply_en || io_supply_en)
    && (!io_supply_en || analog_supply_en)) else $error("rail order");
  a_pair_rails: assert property (analog_supply_en == pixel_array_supply_en)
    else $error("pixel rail");
  a_clk_settled: assert property ($rose(external_input_clock) |-> $past(serial_output_supply_en, 200))
    else $error("early clock");
  a_reset_rails: assert property (!serial_output_supply_en |-> !sensor_reset_n && !external_input_clock)
    else $error("reset with rail off");
  a_reset_hold: assert property ($rose(sensor_reset_n) |-> hold_q >= MS_CYC - 3)
    else $error("short reset");
  a_init_wait: assert property ($rose(ser_req) |-> init_q >= INIT_CLKS - 1)
    else $error("early config");
  a_pll_lock: assert property ($rose(ser_req) && son |-> lock_q >= PLL_CYC - 1)
    else $error("early stream");
  a_stream_off: assert property ($fell(serial_output_supply_en) |-> !strm_q)
    else $error("still streaming");
  a_off_time: assert property ($rose(pll_supply_en) |-> off_q >= OFF_CYC - 1)
    else $error("short off time");
  a_ser_hold: assert property (ser_req && !ser_ack |=> ser_req && $stable(ser_addr) && $stable(ser_data))
    else $error("serial request moved");
  c_stream_on: cover property (son && ser_ack);
  c_power_off: cover property ($fell(pll_supply_en));
  c_reset_up: cover property ($rose(sensor_reset_n));
endmodule : spr_checker

bind spr_sequencer spr_checker #(.MS_CYC(MS_CYC), .PLL_CYC(PLL_CYC), .INIT_CLKS(INIT_CLKS), .OFF_CYC(OFF_CYC)) u_chk (
  .aclk(aclk), .aresetn(aresetn), .pll_supply_en(pll_supply_en), .analog_supply_en(analog_supply_en),
  .pixel_array_supply_en(pixel_array_supply_en), .io_supply_en(io_supply_en), .core_supply_en(core_supply_en),
  .serial_output_supply_en(serial_output_supply_en), .external_input_clock(external_input_clock),
  .sensor_reset_n(sensor_reset_n), .ser_req(ser_req), .ser_addr(ser_addr), .ser_data(ser_data), .ser_ack(ser_ack));

// ### verif/spr_sensor_model.sv
// Behavioural model of the image sensor seen from the sequencer
`timescale 1ns/1ps
`include "spr_consts.svh"
module spr_sensor_model #(
  parameter int          INIT_CLKS = 10,
  parameter int          ROW_CYC   = 8,
  parameter logic [15:0] CTRL_RST  = 16'h0000
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ext_clk,
  input  wire logic        reset_n,
  input  wire logic        rails_on,
  input  wire logic        ser_req,
  input  wire logic [15:0] ser_addr,
  input  wire logic [15:0] ser_data,
  input  wire logic [3:0]  ack_dly,
  output logic             ser_ack,
  output logic [15:0]      sensor_control_q,
  output logic             streaming_q,
  output logic             fault_q,
  output logic [7:0]       writes_q
);
  logic [17:0] init_q;
  logic [3:0]  wait_q, row_q;
  logic        clkp_q;
  always_ff @(posedge aclk) begin
    clkp_q <= ext_clk;
    if (!reset_n) init_q <= '0;
    else if (ext_clk && !clkp_q && init_q < INIT_CLKS) init_q <= init_q + 18'h1;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {ser_ack, wait_q, fault_q, writes_q} <= '0;
      sensor_control_q <= CTRL_RST;
    end else if (ser_ack) begin
      ser_ack <= 1'b0;
      wait_q  <= '0;
    end else if (ser_req && wait_q < ack_dly) wait_q <= wait_q + 4'h1;
    else if (ser_req) begin
      ser_ack  <= 1'b1;
      writes_q <= writes_q + 8'h1;
      if (!reset_n || init_q < INIT_CLKS) fault_q <= 1'b1;
      if (ser_addr == `SPR_SENSOR_CONTROL) sensor_control_q <= ser_data;
    end
    if (aresetn && !rails_on && streaming_q) fault_q <= 1'b1;
  end
  always_ff @(posedge aclk) begin
    if (!reset_n) begin
      streaming_q <= 1'b0;
      row_q       <= '0;
    end else if (sensor_control_q[`SPR_STREAM_BIT]) begin
      streaming_q <= 1'b1;
      row_q       <= '0;
    end else if (streaming_q) begin
      row_q <= row_q + 4'h1;
      if (row_q == ROW_CYC - 1) streaming_q <= 1'b0;
    end
  end
endmodule : spr_sensor_model

// ### verif/testbench.sv
// Self-checking testbench for the sensor power and reset sequencer
`timescale 1ns/1ps
`include "spr_consts.svh"
`define CHK(nm, ex, sn) begin compares++; if ((sn) !== (ex)) begin err_count++; \
  $display("wrong value %s expected %h seen %h", nm, ex, sn); end end
module testbench;
  logic        aclk = 1'b0, aresetn = 1'b0;
  logic [7:0]  awaddr = '0, araddr = '0, nwr;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = '0, rdata, rd;
  logic [3:0]  wstrb = '0, ack_dly = '0;
  logic        awready, wready, bvalid, arready, rvalid, ser_req, ser_ack, xclk, rst_n, strm, fault;
  logic        pll, ana, pix, io, core, ser;
  logic [1:0]  bresp, rresp, rs;
  logic [15:0] ser_addr, ser_data, sctl;
  int          err_count = 0;
  int          compares = 0;
  always #20 aclk = ~aclk;
  spr_sequencer #(.MS_CYC(20), .PLL_CYC(20), .INIT_CLKS(10), .OFF_CYC(30), .EXT_HALF(1)) uut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .pll_supply_en(pll), .analog_supply_en(ana), .pixel_array_supply_en(pix), .io_supply_en(io),
    .core_supply_en(core), .serial_output_supply_en(ser), .external_input_clock(xclk), .sensor_reset_n(rst_n),
    .ser_req(ser_req), .ser_addr(ser_addr), .ser_data(ser_data), .ser_ack(ser_ack));
  spr_sensor_model #(.INIT_CLKS(10)) u_sensor (
    .aclk(aclk), .aresetn(aresetn), .ext_clk(xclk), .reset_n(rst_n), .rails_on(ser), .ser_req(ser_req),
    .ser_addr(ser_addr), .ser_data(ser_data), .ack_dly(ack_dly), .ser_ack(ser_ack), .sensor_control_q(sctl),
    .streaming_q(strm), .fault_q(fault), .writes_q(nwr));
  // *****
  // Bus tasks
  // *****
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hf);
    logic ta, tw, tb;
    @(posedge aclk);
    {awaddr, wdata, wstrb, awvalid, wvalid, bready} <= {a, d, s, 3'b111};
    do begin
      @(negedge aclk);
      {ta, tw, tb, rs} = {awvalid && awready, wvalid && wready, bvalid, bresp};
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end while (!tb);
    bready <= 1'b0;
  endtask : wr
  task automatic rd_reg(input logic [7:0] a);
    logic ta, tr;
    @(posedge aclk);
    {araddr, arvalid, rready} <= {a, 2'b11};
    do begin
      @(negedge aclk);
      {ta, tr, rd, rs} = {arvalid && arready, rvalid, rdata, rresp};
      @(posedge aclk);
      if (ta) arvalid <= 1'b0;
    end while (!tr);
    rready <= 1'b0;
  endtask : rd_reg
  task automatic wait_st(input logic [3:0] s);
    do rd_reg(`SPR_ADDR_STATUS); while (rd[3:0] !== s);
  endtask : wait_st
  // *****
  // Scenarios
  // *****
  task automatic t_regs;
    logic [7:0]  a [4] = '{`SPR_ADDR_CTRL, `SPR_ADDR_STATUS, `SPR_ADDR_STREAMVAL, `SPR_ADDR_STANDBY};
    logic [31:0] e [4] = '{32'h0, 32'h0, {16'h0, `SPR_STREAMVAL_RST}, {16'h0, `SPR_STANDBY_RST}};
    for (int i = 0; i < 4; i++) begin
      rd_reg(a[i]);
      `CHK("reset value", e[i], rd)
    end
    rd_reg(8'h14);
    `CHK("unmapped read", {`SPR_RESP_SLVERR, 32'h0}, {rs, rd})
    wr(8'h14, 32'hffff_ffff);
    `CHK("unmapped write", `SPR_RESP_SLVERR, rs)
    wr(`SPR_ADDR_STREAMVAL, 32'h0000_ab10, 4'h1);
    wr(`SPR_ADDR_STANDBY, 32'h0000_0001);
    rd_reg(`SPR_ADDR_STREAMVAL);
    `CHK("streamval", 32'h0000_0010, rd)
  endtask : t_regs
  task automatic t_up;
    wr(`SPR_ADDR_CTRL, 32'h1 << `SPR_CTRL_UP);
    wait_st(spr_pkg::ST_CONFIG);
    `CHK("status up", 7'h7f, rd[11:5])
    ack_dly <= 4'h5;
    wr(`SPR_ADDR_SERCMD, 32'h30b0_0042);
    do rd_reg(`SPR_ADDR_STATUS); while (rd[4] !== 1'b0);
    `CHK("config write", 9'h001, {fault, nwr})
    wr(`SPR_ADDR_CTRL, 32'h1 << `SPR_CTRL_CFG_DONE);
    wait_st(spr_pkg::ST_STREAMING);
    `CHK("stream word", 16'h0014, sctl)
    `CHK("streaming", 1'b1, strm)
    wr(`SPR_ADDR_SERCMD, 32'h30b0_0001);
    `CHK("late sercmd", 8'h2, nwr)
  endtask : t_up
  task automatic t_down;
    ack_dly <= 4'h0;
    wr(`SPR_ADDR_CTRL, 32'h1 << `SPR_CTRL_DOWN);
    wait_st(spr_pkg::ST_OFF);
    `CHK("stream cleared", 16'h0010, sctl)
    `CHK("pins off", 9'h000, {pll, ana, pix, io, core, ser, xclk, rst_n, fault})
  endtask : t_down
  task automatic t_abort;
    wr(`SPR_ADDR_CTRL, 32'h1 << `SPR_CTRL_UP);
    wait_st(spr_pkg::ST_INIT_WAIT);
    wr(`SPR_ADDR_CTRL, 32'h1 << `SPR_CTRL_DOWN);
    wait_st(spr_pkg::ST_OFF);
    `CHK("abort writes", 8'h3, nwr)
    `CHK("abort pins", 8'h00, {pll, ana, pix, io, core, ser, xclk, rst_n})
  endtask : t_abort
  task automatic report_and_stop;
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_up();
    t_down();
    t_abort();
    report_and_stop();
  end
  initial begin
    repeat (40000) @(posedge aclk);
    err_count++;
    report_and_stop();
  end
endmodule : testbench
